// [include/porc_pkg.sv]
/*
 Constants for the power-on reset controller that drives the reset request
 pin of the powered device. Assumes a single 50 MHz clock.
*/
// Contract
// R1: Low request holds whole device in reset
// R2: Device reset output released after delay
// R3: Supply-good follows battery supply threshold
// R4: Supply-good gates I/O cells safe
// R5: Host holds request low 10 ms
// R6: Other supplies on 1 ms before release
// R7: Request low 600 us after supplies settle
// R8: Drive request low before power-down
// R9: Blackout hysteresis between two thresholds
// R10: Looped supply-good trips reset on blackout
// R11: Blackout comparator off after power-up; device model keeps it on
// R12: Firmware enables blackout only high power
// R13: Brownout in low power enables blackout
// R14: Reset asserts async, releases synchronized
`default_nettype none
package porc_pkg;
	localparam int CLK_HZ       = 50000000; // System clock rate
	localparam int RST_HOLD_US  = 10000;    // Least external reset hold, us
	localparam int SETTLE_US    = 600;      // Least hold after supplies settle, us
	localparam int SUP_LEAD_US  = 1000;     // Supplies on before release, us
	// Least times scale to whole cycles, with no rounding up
	localparam int RST_HOLD_CYC = (RST_HOLD_US * (CLK_HZ / 1000000) + 0);
	localparam int SETTLE_CYC   = (SETTLE_US * (CLK_HZ / 1000000) + 0);
	localparam int SUP_LEAD_CYC = (SUP_LEAD_US * (CLK_HZ / 1000000) + 0);
	localparam int CNT_W        = 20;       // Hold counter width
endpackage
`default_nettype wire

// [logic/porc_ctrl.sv]
/*
 Host-side reset sequencer. Drives the device reset request pin as an
 open-drain output, holds it low on power-up for the longer of the settle and supply-lead times and on
 each reset command seen in the run state without a power-down request for the external hold time, drives it low ahead of
 power-down, and watches the device reset output and supply-good pin.
 Assumes all inputs but arst_n are synchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none
module porc_ctrl
	import porc_pkg::*;
#(
	parameter int RST_HOLD = porc_pkg::RST_HOLD_CYC, // Reset command hold cycles
	parameter int SETTLE   = porc_pkg::SETTLE_CYC,   // Power-up hold cycles
	parameter int SUP_LEAD = porc_pkg::SUP_LEAD_CYC  // Supply lead before release
)
(
	input  wire logic clock,            // 50 MHz clock
	input  wire logic arst_n,           // Async reset, active low
	input  wire logic supplies_ok,      // All supplies settled
	input  wire logic reset_cmd,        // Pulse: reset the device
	input  wire logic power_down_req,   // Level: power-down coming
	input  wire logic reset_request_i,  // Request pin level read back
	input  wire logic dev_reset_n_i,    // Device reset output level
	input  wire logic supply_good_out,  // Device supply-good pin
	output logic      reset_request_o,  // Request pin output value
	output logic      reset_request_oe, // High while pulling low
	output logic      dev_ready,        // Device out of reset
	output logic      busy              // Sequencer holding request
);
	import porc_pkg::*;

	// Sequencer states, one-hot
	typedef enum logic [3:0] {
		ST_PWRUP = 4'h1, // Power-up hold
		ST_RUN   = 4'h2, // Request released
		ST_HOLD  = 4'h4, // Commanded reset hold
		ST_DOWN  = 4'h8  // Power-down hold
	} porc_state_t;

	porc_state_t      state_q, state_d;  // Sequencer state
	logic [CNT_W-1:0] cnt_q, cnt_d;      // Hold counter
	logic             oe_q, oe_d;        // Pull-low enable
	logic             rdy_q, rdy_d;      // Ready flag

	// Counter expiry test
	function automatic logic hit(input logic [CNT_W-1:0] c, input int n);
		hit = (c >= CNT_W'(n - 1));
	endfunction

	// Longer of the two power-up holds
	localparam int PWR_HOLD = (SETTLE > SUP_LEAD) ? SETTLE : SUP_LEAD;

	// Next state and counter
	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q + CNT_W'(1);
		oe_d    = oe_q;
		// Ready only with supply good and the device out of reset
		// Blackout monitor enable is left to device firmware [R12]
		rdy_d   = dev_reset_n_i & supply_good_out & ~oe_q; // [R4]
		unique case (state_q)
			ST_PWRUP:
			begin
				oe_d = 1'b1; // [R7]
				if (!supplies_ok)
					cnt_d = '0; // Restart hold until supplies settle
				else if (hit(cnt_q, PWR_HOLD))
				begin
					state_d = ST_RUN; // [R6]
					oe_d    = 1'b0;
				end
			end
			ST_RUN:
			begin
				cnt_d = '0;
				if (power_down_req)
				begin
					state_d = ST_DOWN; // [R8]
					oe_d    = 1'b1;
				end
				else if (reset_cmd)
				begin
					state_d = ST_HOLD;
					oe_d    = 1'b1;
				end
			end
			ST_HOLD:
			begin
				if (power_down_req)
				begin
					state_d = ST_DOWN; // [R8]
					cnt_d   = '0;
				end
				else if (hit(cnt_q, RST_HOLD))
				begin
					state_d = ST_RUN; // [R5]
					oe_d    = 1'b0;
				end
			end
			ST_DOWN:
			begin
				oe_d  = 1'b1; // [R8]
				cnt_d = '0;
				if (!power_down_req)
					state_d = ST_PWRUP; // Fresh power-up hold
			end
		endcase
	end

	// State registers
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= ST_PWRUP;
			cnt_q   <= '0;
			oe_q    <= 1'b1;
			rdy_q   <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			oe_q    <= oe_d;
			rdy_q   <= rdy_d;
		end
	end

	// Drive value tied low, other outputs straight from flops
	assign reset_request_o  = 1'b0;
	always_comb
	begin
		reset_request_oe = oe_q; // [R1]
		dev_ready        = rdy_q;
		busy             = oe_q;
	end

	// Request held low for 8 cycles after a commanded hold starts
	chk_hold_length: assert property (@(posedge clock) disable iff (!arst_n) // [R5]
		(state_q == ST_RUN && state_d == ST_HOLD) |=> oe_q [*8])
		else $error("reset request released too early");
	chk_down_low: assert property (@(posedge clock) disable iff (!arst_n) // [R8]
		(state_q == ST_DOWN) |-> oe_q)
		else $error("request not low during power-down");
	chk_pwrup_low: assert property (@(posedge clock) disable iff (!arst_n) // [R7]
		(state_q == ST_PWRUP) |-> oe_q)
		else $error("request not low during power-up");
	chk_settle_wait: assert property (@(posedge clock) disable iff (!arst_n) // [R6]
		(state_q == ST_PWRUP && !supplies_ok) |=> state_q == ST_PWRUP)
		else $error("left power-up before supplies settled");
	chk_ready_gate: assert property (@(posedge clock) disable iff (!arst_n) // [R4]
		rdy_q |-> $past(supply_good_out) && $past(dev_reset_n_i))
		else $error("ready without supply good");
	chk_release_run: assert property (@(posedge clock) disable iff (!arst_n) // [R1]
		(state_q == ST_RUN && $past(state_q) == ST_RUN) |-> !oe_q)
		else $error("request held in run");
	chk_cmd_start: assert property (@(posedge clock) disable iff (!arst_n) // [R5]
		(state_q == ST_RUN && reset_cmd && !power_down_req) |=> state_q == ST_HOLD && oe_q)
		else $error("reset command not taken");
	chk_down_entry: assert property (@(posedge clock) disable iff (!arst_n) // [R8]
		(state_q != ST_DOWN && state_q != ST_PWRUP && power_down_req) |=> state_q == ST_DOWN)
		else $error("power-down not taken");

	// Further checks on the hold lengths and the pin readback.
	// The counter is cleared on every entry to a hold state, so
	// the exit edge must see it at exactly one less than the hold.
	// A shorter count would release the pin early and break the
	// least hold times that the device needs; a longer one only
	// wastes time, but still points at a broken counter.
	// The readback check catches a pin that some other driver
	// holds high while this sequencer believes it pulls low.

	// Pin readback low whenever we pull it
	chk_pin_low: assert property (@(posedge clock) disable iff (!arst_n) // [R1]
		oe_q |-> !reset_request_i)
		else $error("request pin not low while pulled");

	// Power-up release only after the full longer hold
	chk_pwrup_len: assert property (@(posedge clock) disable iff (!arst_n) // [R6]
		(state_q == ST_PWRUP && state_d == ST_RUN) |-> cnt_q == CNT_W'(PWR_HOLD - 1))
		else $error("power-up hold cut short");

	// Power-up release only after supplies stood settled
	chk_settle_len: assert property (@(posedge clock) disable iff (!arst_n) // [R7]
		(state_q == ST_PWRUP && state_d == ST_RUN) |-> cnt_q >= CNT_W'(SETTLE - 1))
		else $error("settle hold cut short");

	// Commanded hold ends at exactly the hold count
	chk_hold_exit: assert property (@(posedge clock) disable iff (!arst_n) // [R5]
		(state_q == ST_HOLD && state_d == ST_RUN) |-> cnt_q == CNT_W'(RST_HOLD - 1))
		else $error("commanded hold wrong length");

	// Ready drops once supply-good falls
	chk_ready_drop: assert property (@(posedge clock) disable iff (!arst_n) // [R4]
		!supply_good_out |=> !rdy_q)
		else $error("ready kept without supply good");

	// Main scenarios seen
	cov_pwrup: cover property (@(posedge clock) state_q == ST_PWRUP ##1 state_q == ST_RUN);
	cov_blackout: cover property (@(posedge clock) rdy_q && !supply_good_out ##1 !rdy_q);
	cov_cmd_again: cover property (@(posedge clock) state_q == ST_HOLD ##1 state_q == ST_RUN
		##[1:50] state_q == ST_HOLD);
	cov_cmd: cover property (@(posedge clock) state_q == ST_HOLD ##1 state_q == ST_RUN);
	cov_down: cover property (@(posedge clock) state_q == ST_DOWN ##1 state_q == ST_PWRUP);
endmodule
`default_nettype wire

// [tb/porc_dev_model.sv]
/*
 Model of the powered device: reset output and supply-good pin.
 Assumes the bench resolves the request pin level.
*/
`timescale 1ns/1ps
`default_nettype none
module porc_dev_model
#(
	parameter int DLY = 5 // Request rise to reset release
)
(
	input  wire logic clock,     // Bench clock
	input  wire logic main_battery_ok, // Battery above threshold
	input  wire logic req_pin,   // Request pin level
	output logic      dev_rst_n, // Open-drain reset output
	output logic      sup_good   // Supply-good pin
);
	int cnt = 0; // Cycles since request rose
	// Comparator kept on, as after firmware enable or brownout re-enable
	assign sup_good = main_battery_ok;
	// Low request resets at once, release counts up
	always @(posedge clock or negedge req_pin)
		if (!req_pin)
			cnt <= 0;
		else if (cnt < DLY)
			cnt <= cnt + 1;
	assign dev_rst_n = req_pin && (cnt >= DLY);
endmodule
`default_nettype wire

// [tb/porc_ctrl_bench.sv]
/*
 Bench for the host reset sequencer with a device model.
 Assumes shortened hold counts and a pulled-up request pin.
*/
`timescale 1ns/1ps
`default_nettype none
module porc_ctrl_bench;
	import porc_pkg::*;
	localparam int HOLD = 20; // Command hold cycles
	localparam int PWR  = 12; // Longer power-up hold
	logic clock, arst_n, sup_ok, cmd, pdn, vb;
	wire logic pin, rst_n, sg, oe, ro, rdy, busy;
	int fail_count = 0;
	int total_checks = 0;
	int cyc = 0;
	// Open drain with pull-up, supply-good looped back
	assign pin = (oe ? ro : 1'b1) & sg;
	porc_ctrl #(.RST_HOLD(HOLD), .SETTLE(10), .SUP_LEAD(PWR)) dut (.clock(clock),
		.arst_n(arst_n), .supplies_ok(sup_ok), .reset_cmd(cmd), .power_down_req(pdn),
		.reset_request_i(pin), .dev_reset_n_i(rst_n), .supply_good_out(sg),
		.reset_request_o(ro), .reset_request_oe(oe), .dev_ready(rdy), .busy(busy));
	porc_dev_model #(.DLY(5)) dev (.clock(clock), .main_battery_ok(vb), .req_pin(pin),
		.dev_rst_n(rst_n), .sup_good(sg));
	task automatic end_sim;
		$display("checks %0d failures %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic e, input logic s);
		total_checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("[FAIL] %s expected %b seen %b", n, e, s);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// Power-up hold, then device leaves reset
	task automatic t_up;
		step(PWR - 2);
		chk("busy", 1'b1, busy);
		step(5);
		chk("oe", 1'b0, oe);
		step(9);
		chk("ready", 1'b1, rdy);
	endtask
	// Reset command holds the pin low
	task automatic t_cmd;
		cmd = 1'b1;
		step(1);
		cmd = 1'b0;
		chk("oe", 1'b1, oe);
		chk("drive", 1'b0, ro);
		step(HOLD - 3);
		chk("oe", 1'b1, oe);
		chk("ready", 1'b0, rdy);
		step(6);
		chk("oe", 1'b0, oe);
		step(9);
		chk("ready", 1'b1, rdy);
	endtask
	// Power-down holds until dropped
	task automatic t_pdn;
		pdn = 1'b1;
		step(HOLD + 10);
		chk("oe", 1'b1, oe);
		pdn = 1'b0;
		t_up;
	endtask
	// Blackout drops supply-good and the device
	task automatic t_blk;
		vb = 1'b0;
		step(2);
		chk("ready", 1'b0, rdy);
		vb = 1'b1;
		step(12);
		chk("ready", 1'b1, rdy);
	endtask
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// Cycle ceiling
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 400)
		begin
			fail_count++;
			end_sim;
		end
	end
	initial
	begin
		{arst_n, cmd, pdn, sup_ok, vb} = 5'h01;
		step(6);
		chk("busy", 1'b1, busy);
		arst_n = 1'b1;
		sup_ok = 1'b1;
		t_up;
		t_cmd;
		t_pdn;
		t_blk;
		end_sim;
	end
endmodule
`default_nettype wire
